// [shared/ddbp_pkg.sv]
/*
 * Shared constants and carrier types for the DDR2 burst and precharge block.
 * Assumes a 32-bit APB register bus and a sampled command clock.
 */
package ddbp_pkg;
	localparam int DATA_W     = 16;
	localparam int MASK_W     = 2;
	localparam int COL_W      = 9;
	localparam int ADDR_W     = 13;
	localparam int LINE_DEPTH = 32;
	localparam int MEM_WORDS  = 256;
	localparam int CLOSE_BIT  = 10;

	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] EXT_OFS  = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;

	localparam int BL_LSB    = 0;
	localparam int ORDER_BIT = 3;
	localparam int CL_LSB    = 4;
	localparam int WR_LSB    = 9;
	localparam int AL_LSB    = 3;

	localparam logic [2:0]  BL_FOUR    = 3'h2;
	localparam logic [2:0]  BL_EIGHT   = 3'h3;
	localparam logic [2:0]  LAST_FOUR  = 3'h3;
	localparam logic [2:0]  LAST_EIGHT = 3'h7;
	localparam logic [4:0]  HALF_FOUR  = 5'h02;
	localparam logic [4:0]  HALF_EIGHT = 5'h04;
	localparam logic [31:0] MODE_RST   = 32'h0000_0432;
	localparam logic [31:0] EXT_RST    = 32'h0000_0000;

	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [1:0]        bank;
		logic [ADDR_W-1:0] addr;
	} ddbp_pins_type;

	typedef struct packed {
		logic             valid;
		logic             write;
		logic             close;
		logic [1:0]       bank;
		logic [COL_W-1:0] col;
	} ddbp_col_cmd_type;
endpackage

// [src/ddbp_core.sv]
/*
 * Column access, burst ordering, write mask and precharge of a four-bank
 * DDR2 memory, with configuration over APB.
 * Assumes link clock, pins and data are asynchronous to clk and much slower.
 */
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
module ddbp_core (
	input  logic                         clk,           // System clock
	input  logic                         sys_rst,       // Synchronous reset
	input  logic                         psel,          // APB select
	input  logic                         penable,       // APB enable
	input  logic                         pwrite,        // APB direction
	input  logic [7:0]                   paddr,         // APB byte address
	input  logic [31:0]                  pwdata,        // APB write data
	output logic [31:0]                  prdata,        // APB read data
	output logic                         pready,        // APB ready
	output logic                         pslverr,       // APB error
	input  logic                         link_clk,      // Command clock
	input  ddbp_pkg::ddbp_pins_type      cmd_pins,      // Command and address
	input  logic [ddbp_pkg::DATA_W-1:0]  dq_in,         // Data from pins
	output logic [ddbp_pkg::DATA_W-1:0]  dq_out,        // Data to pins
	output logic                         dq_oe_n,       // Data drive, low drives
	input  logic [ddbp_pkg::MASK_W-1:0]  write_byte_mask, // Byte mask
	output logic                         strobe_out,    // Read strobe
	output logic                         strobe_oe_n,   // Strobe drive, low drives
	output logic [3:0]                   bank_open      // Open bank flags
);
	logic [2:0]                      link_q;
	ddbp_pkg::ddbp_pins_type         pins_s0_q, pins_q;
	logic [ddbp_pkg::DATA_W-1:0]     dq_s0_q, dq_q;
	logic [ddbp_pkg::MASK_W-1:0]     mask_s0_q, mask_q;
	logic [31:0]                     mode_q, ext_q, prdata_q, prdata_d;
	logic                            pready_q, pslverr_q, pslverr_d;
	ddbp_pkg::ddbp_col_cmd_type      line_q [ddbp_pkg::LINE_DEPTH];
	ddbp_pkg::ddbp_col_cmd_type      new_cmd, go_e, rc_e, wc_e;
	logic [ddbp_pkg::DATA_W-1:0]     mem_q [ddbp_pkg::MEM_WORDS];
	logic                            bu_active_q, bu_active_d, bu_write_q, bu_write_d;
	logic [2:0]                      bu_cnt_q, bu_cnt_d;
	logic [ddbp_pkg::COL_W-1:0]      bu_start_q, bu_start_d;
	logic [1:0]                      bu_bank_q, bu_bank_d;
	logic [ddbp_pkg::DATA_W-1:0]     dq_out_q, dq_out_d;
	logic                            dq_oe_n_q, dq_oe_n_d, strobe_q, strobe_d;
	logic                            strobe_oe_n_q, strobe_oe_n_d;
	logic [3:0]                      bank_open_q, bank_open_d;

	// Edge detection reads only the second and third stages
	wire rise    = link_q[1] & ~link_q[2];
	wire fall    = ~link_q[1] & link_q[2];
	wire edge_ev = rise | fall;

	wire [2:0] bl_f    = mode_q[ddbp_pkg::BL_LSB +: 3];
	wire       len8    = (bl_f == ddbp_pkg::BL_EIGHT);
	wire       ilv     = mode_q[ddbp_pkg::ORDER_BIT];
	wire [4:0] al      = {2'h0, ext_q[ddbp_pkg::AL_LSB +: 3]};
	wire [4:0] cl      = {2'h0, mode_q[ddbp_pkg::CL_LSB +: 3]};
	wire [4:0] wrc     = {2'h0, mode_q[ddbp_pkg::WR_LSB +: 3]} + 5'h01;
	wire [4:0] half    = len8 ? ddbp_pkg::HALF_EIGHT : ddbp_pkg::HALF_FOUR;
	wire [2:0] last    = len8 ? ddbp_pkg::LAST_EIGHT : ddbp_pkg::LAST_FOUR;
	wire [4:0] rd_dly  = al + cl;
	wire [4:0] wr_dly  = rd_dly - 5'h01;
	wire [4:0] rd_tap  = rd_dly - 5'h01;
	wire [4:0] pre_tap = rd_dly - 5'h02;
	wire [4:0] wr_tap  = wr_dly - 5'h01;
	// Closing taps use the configured length even after an interrupt
	wire [4:0] rc_tap  = al + half - 5'h01;
	wire [4:0] wc_tap  = wr_dly + half + wrc - 5'h01;

	// Command decode; the old burst-stop encoding falls through as a no-op
	wire sel     = rise & ~pins_q.cs_n;
	wire rd_cmd  = sel & pins_q.ras_n & ~pins_q.cas_n & pins_q.we_n;
	wire wr_cmd  = sel & pins_q.ras_n & ~pins_q.cas_n & ~pins_q.we_n;
	wire act_cmd = sel & ~pins_q.ras_n & pins_q.cas_n & pins_q.we_n;
	wire pre_cmd = sel & ~pins_q.ras_n & pins_q.cas_n & ~pins_q.we_n;
	wire pre_all = pins_q.addr[ddbp_pkg::CLOSE_BIT];

	assign new_cmd = '{valid: rd_cmd | wr_cmd, write: wr_cmd,
		close: pins_q.addr[ddbp_pkg::CLOSE_BIT], bank: pins_q.bank,
		col: pins_q.addr[ddbp_pkg::COL_W-1:0]};

	wire rd_go  = rise & line_q[rd_tap].valid & ~line_q[rd_tap].write;
	wire wr_go  = rise & line_q[wr_tap].valid & line_q[wr_tap].write;
	wire rd_pre = rise & line_q[pre_tap].valid & ~line_q[pre_tap].write;
	wire go     = rd_go | wr_go;
	assign go_e = rd_go ? line_q[rd_tap] : line_q[wr_tap];
	assign rc_e = line_q[rc_tap];
	assign wc_e = line_q[wc_tap];
	wire rd_close = rise & rc_e.valid & ~rc_e.write & rc_e.close;
	wire wr_close = rise & wc_e.valid & wc_e.write & wc_e.close;

	// Burst column order within the four or eight word group
	function automatic logic [ddbp_pkg::COL_W-1:0] burst_col(
		input logic [ddbp_pkg::COL_W-1:0] s,
		input logic [2:0]                 i,
		input logic                       l8,
		input logic                       il);
		logic [1:0] lo;
		logic       hi;
		lo = il ? (s[1:0] ^ i[1:0]) : (s[1:0] + i[1:0]);
		hi = l8 ? (s[2] ^ i[2]) : s[2];
		return {s[ddbp_pkg::COL_W-1:3], hi, lo};
	endfunction

	wire [2:0]                 beat      = go ? 3'h0 : bu_cnt_q;
	wire [ddbp_pkg::COL_W-1:0] src_start = go ? go_e.col : bu_start_q;
	wire [1:0]                 src_bank  = go ? go_e.bank : bu_bank_q;
	wire                       cur_write = go ? wr_go : bu_write_q;
	wire [ddbp_pkg::COL_W-1:0] beat_col  = burst_col(src_start, beat, len8, ilv);
	wire [7:0]                 mem_idx   = {src_bank, beat_col[5:0]};
	wire                       emit      = go | (bu_active_q & edge_ev);
	// Beats past the programmed count never reach the array
	wire                       mem_we    = emit & cur_write;

	always_comb begin
		bu_active_d = bu_active_q;
		bu_write_d  = bu_write_q;
		bu_cnt_d    = bu_cnt_q;
		bu_start_d  = bu_start_q;
		bu_bank_d   = bu_bank_q;
		if (go) begin
			// A legal interrupt simply restarts the engine
			bu_active_d = 1'b1;
			bu_write_d  = wr_go;
			bu_cnt_d    = 3'h1;
			bu_start_d  = go_e.col;
			bu_bank_d   = go_e.bank;
		end else if (bu_active_q && edge_ev) begin
			bu_cnt_d = bu_cnt_q + 3'h1;
			if (bu_cnt_q == last) begin
				bu_active_d = 1'b0;
			end
		end
	end

	always_comb begin
		dq_out_d      = dq_out_q;
		dq_oe_n_d     = dq_oe_n_q;
		strobe_d      = strobe_q;
		strobe_oe_n_d = strobe_oe_n_q;
		if (emit && !cur_write) begin
			dq_out_d      = mem_q[mem_idx];
			dq_oe_n_d     = 1'b0;
			strobe_d      = rise;
			strobe_oe_n_d = 1'b0;
		end else if (rd_pre && !bu_active_q) begin
			dq_oe_n_d     = 1'b1;
			strobe_d      = 1'b0;
			strobe_oe_n_d = 1'b0;
		end else if (rise && !(bu_active_q && !bu_write_q)) begin
			// Postamble ends at the rise after the last beat
			dq_oe_n_d     = 1'b1;
			strobe_d      = 1'b0;
			strobe_oe_n_d = 1'b1;
		end
	end

	always_comb begin
		bank_open_d = bank_open_q;
		if (pre_cmd && pre_all) begin
			bank_open_d = 4'h0;
		end else if (pre_cmd) begin
			bank_open_d[pins_q.bank] = 1'b0;
		end
		if (rd_close) begin
			bank_open_d[rc_e.bank] = 1'b0;
		end
		if (wr_close) begin
			bank_open_d[wc_e.bank] = 1'b0;
		end
		if (act_cmd) begin
			bank_open_d[pins_q.bank] = 1'b1;
		end
	end

	// APB: one wait state, so pready comes from a flop
	wire apb_acc  = psel & penable & ~pready_q;
	wire apb_done = psel & penable & pready_q;
	wire hit_mode = (paddr == ddbp_pkg::MODE_OFS);
	wire hit_ext  = (paddr == ddbp_pkg::EXT_OFS);
	wire hit_stat = (paddr == ddbp_pkg::STAT_OFS);
	wire bl_legal = (pwdata[ddbp_pkg::BL_LSB +: 3] == ddbp_pkg::BL_FOUR)
		| (pwdata[ddbp_pkg::BL_LSB +: 3] == ddbp_pkg::BL_EIGHT);
	wire [2:0] bl_new = bl_legal ? pwdata[ddbp_pkg::BL_LSB +: 3] : bl_f;
	wire [31:0] stat_word = {26'h0, bu_write_q, bu_active_q, bank_open_q};

	assign prdata_d  = (~pwrite & hit_mode) ? mode_q
		: (~pwrite & hit_ext) ? ext_q
		: (~pwrite & hit_stat) ? stat_word : 32'h0000_0000;
	assign pslverr_d = ~(hit_mode | hit_ext | hit_stat);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			mode_q    <= ddbp_pkg::MODE_RST;
			ext_q     <= ddbp_pkg::EXT_RST;
		end else begin
			pready_q  <= apb_acc;
			pslverr_q <= apb_acc & pslverr_d;
			prdata_q  <= apb_acc ? prdata_d : 32'h0000_0000;
			if (apb_done && pwrite && hit_mode) begin
				mode_q <= {pwdata[31:3], bl_new};
			end
			if (apb_done && pwrite && hit_ext) begin
				ext_q <= pwdata;
			end
		end
	end

	// Two-stage synchronisers for everything arriving from the pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_q    <= 3'h0;
			pins_s0_q <= '1;
			pins_q    <= '1;
			dq_s0_q   <= 16'h0000;
			dq_q      <= 16'h0000;
			mask_s0_q <= 2'h3;
			mask_q    <= 2'h3;
		end else begin
			link_q    <= {link_q[1:0], link_clk};
			pins_s0_q <= cmd_pins;
			pins_q    <= pins_s0_q;
			dq_s0_q   <= dq_in;
			dq_q      <= dq_s0_q;
			mask_s0_q <= write_byte_mask;
			mask_q    <= mask_s0_q;
		end
	end

	// Command delay line, one stage per command clock
	for (genvar k = 0; k < ddbp_pkg::LINE_DEPTH; k++) begin : g_line
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				line_q[k] <= '0;
			end else if (rise) begin
				line_q[k] <= (k == 0) ? new_cmd : line_q[(k == 0) ? 0 : k - 1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bu_active_q   <= 1'b0;
			bu_write_q    <= 1'b0;
			bu_cnt_q      <= 3'h0;
			bu_start_q    <= 9'h000;
			bu_bank_q     <= 2'h0;
			dq_out_q      <= 16'h0000;
			dq_oe_n_q     <= 1'b1;
			strobe_q      <= 1'b0;
			strobe_oe_n_q <= 1'b1;
			bank_open_q   <= 4'h0;
		end else begin
			bu_active_q   <= bu_active_d;
			bu_write_q    <= bu_write_d;
			bu_cnt_q      <= bu_cnt_d;
			bu_start_q    <= bu_start_d;
			bu_bank_q     <= bu_bank_d;
			dq_out_q      <= dq_out_d;
			dq_oe_n_q     <= dq_oe_n_d;
			strobe_q      <= strobe_d;
			strobe_oe_n_q <= strobe_oe_n_d;
			bank_open_q   <= bank_open_d;
		end
	end

	// Array has no reset; masked lanes keep their old contents
	always_ff @(posedge clk) begin
		for (int b = 0; b < ddbp_pkg::MASK_W; b++) begin
			if (mem_we && !mask_q[b]) begin
				mem_q[mem_idx][b*8 +: 8] <= dq_q[b*8 +: 8];
			end
		end
	end

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign dq_out      = dq_out_q;
	assign dq_oe_n     = dq_oe_n_q;
	assign strobe_out  = strobe_q;
	assign strobe_oe_n = strobe_oe_n_q;
	assign bank_open   = bank_open_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	burst_len_legal_a: assert property (bl_f == ddbp_pkg::BL_FOUR || len8)
		else $error("burst length setting illegal");
	read_launch_a: assert property (rd_go |=> !dq_oe_n_q && strobe_q && !strobe_oe_n_q)
		else $error("read data not driven at read delay");
	read_preamble_a: assert property (rd_pre && !bu_active_q |=> !strobe_oe_n_q && !strobe_q)
		else $error("read preamble missing");
	write_launch_a: assert property (wr_go |=> bu_active_q && bu_write_q && bu_cnt_q == 3'h1)
		else $error("write burst not started at write delay");
	write_ignore_a: assert property (bu_active_q && bu_write_q && edge_ev && !go && bu_cnt_q == last |=> !bu_active_q)
		else $error("write burst ran past its programmed count");
	order_group_a: assert property (emit && !len8 |-> beat_col[8:2] == src_start[8:2])
		else $error("length four burst left its group");
	close_all_a: assert property (pre_cmd && pre_all && !act_cmd |=> bank_open_q == 4'h0)
		else $error("precharge all left a bank open");
	read_autoclose_a: assert property (rd_close && !act_cmd |=> !bank_open_q[$past(rc_e.bank)])
		else $error("read auto close missed");
	write_autoclose_a: assert property (wr_close && !act_cmd |=> !bank_open_q[$past(wc_e.bank)])
		else $error("write auto close missed");

	read_burst_c: cover property (rd_go ##1 bu_active_q [*3]);
	write_burst_c: cover property (wr_go && len8);
	read_interrupt_c: cover property (rd_go && bu_active_q && !bu_write_q);
	precharge_all_c: cover property (pre_cmd && pre_all);
endmodule // ddbp_core

// [verif/ddbp_ctl_model.sv]
/*
 * Behavioural DDR2 controller facing ddbp_core: link clock, commands, write data.
 * Assumes the core samples everything with its own clock; logs core outputs per link edge.
 */
`timescale 1ns/100ps
module ddbp_ctl_model (
	output logic                        link_clk,        // Free-running command clock
	output ddbp_pkg::ddbp_pins_type     cmd_pins,        // Command and address
	output logic [ddbp_pkg::DATA_W-1:0] dq_in,           // Write data
	output logic [ddbp_pkg::MASK_W-1:0] write_byte_mask, // Byte mask
	input  logic [ddbp_pkg::DATA_W-1:0] dq_out,          // Read data
	input  logic                        dq_oe_n,         // Data drive
	input  logic                        strobe_out,      // Read strobe
	input  logic                        strobe_oe_n,     // Strobe drive
	input  logic [3:0]                  bank_open        // Open bank flags
);
	logic [7:0]  he = 8'h00;
	logic [7:0]  c0 = 8'h00;
	logic [22:0] smp [256];

	initial begin
		link_clk = 1'b0;
		cmd_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
		dq_in = 16'h0000;
		write_byte_mask = 2'h0;
		#7;
		forever #100 link_clk = ~link_clk;
	end

	// Sample well inside each beat, past the core's synchroniser lag
	task automatic snap(input logic [7:0] i);
		#125 smp[i] = {dq_oe_n, strobe_oe_n, strobe_out, bank_open, dq_out};
	endtask
	always @(link_clk) he <= he + 8'h01;
	always @(posedge link_clk) snap(he);
	always @(negedge link_clk) snap(he);

	task automatic issue(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
		@(negedge link_clk);
		cmd_pins <= '{1'b0, op[2], op[1], op[0], b, a};
		#1 c0 = he;
		@(negedge link_clk);
		cmd_pins <= '{1'b1, 1'b1, 1'b1, 1'b1, ~b, ~a};
	endtask

	task automatic wr_burst(input logic [1:0] b, input logic [12:0] a, input int wl,
			input int n, input logic [15:0] w [8], input logic [1:0] m [8]);
		issue(3'b100, b, a);
		repeat (wl - 1) @(negedge link_clk);
		for (int k = 0; k < n; k++) begin
			#50;
			dq_in = w[k];
			write_byte_mask = m[k];
			@(link_clk);
		end
		#50;
		dq_in = ~w[n-1];
		write_byte_mask = 2'h0;
		repeat (12) @(posedge link_clk);
	endtask

	task automatic rd_burst(input logic [1:0] b, input logic [12:0] a, input bit stop);
		logic [7:0] keep;
		write_byte_mask = 2'h3;
		issue(3'b101, b, a);
		keep = c0;
		if (stop)
			issue(3'b110, b, a);
		c0 = keep;
		repeat (16) @(posedge link_clk);
	endtask
endmodule // ddbp_ctl_model

// [verif/ddr2_burst_precharge_logic_tb_top.sv]
/*
 * Self-checking bench for ddbp_core: registers, burst order, mask, precharge.
 * Assumes ddbp_ctl_model drives the link side and logs the core per link edge.
 */
`timescale 1ns/100ps
`define CHK(got, want) begin \
	n_tests++; \
	if ((got) !== (want)) begin \
		num_errors++; \
		$display("mismatch %0t: got %h want %h", $time, (got), (want)); \
	end \
end
module ddr2_burst_precharge_logic_tb_top;
	typedef struct packed {
		logic        bl8;
		logic        ilv;
		logic [2:0]  al;
		logic        close;
		logic [2:0]  st;
		logic [31:0] ord;
	} ddbp_row_type;
	logic                    clk     = 1'b0;
	logic                    sys_rst = 1'b1;
	logic                    psel    = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite  = 1'b0;
	logic [7:0]              paddr   = 8'h00;
	logic [31:0]             pwdata  = 32'h0000_0000;
	logic [31:0]             prdata, rd;
	logic                    pready, pslverr, link_clk, dq_oe_n, strobe_out, strobe_oe_n, er;
	ddbp_pkg::ddbp_pins_type cmd_pins;
	logic [15:0]             dq_in, dq_out;
	logic [1:0]              write_byte_mask;
	logic [3:0]              bank_open;
	logic [15:0]             mem [8];
	logic [15:0]             w [8];
	logic [1:0]              m [8];
	int                      num_errors = 0;
	int                      n_tests = 0;
	int                      rl, n, ac;
	// Read orders as absolute columns, first beat in the top nibble
	ddbp_row_type            rows [8] = '{
		'{1'b0, 1'b0, 3'h0, 1'b0, 3'h1, 32'h1230_0000},
		'{1'b0, 1'b1, 3'h0, 1'b0, 3'h1, 32'h1032_0000},
		'{1'b0, 1'b1, 3'h0, 1'b0, 3'h3, 32'h3210_0000},
		'{1'b0, 1'b0, 3'h2, 1'b1, 3'h6, 32'h6745_0000},
		'{1'b1, 1'b0, 3'h0, 1'b0, 3'h1, 32'h1230_5674},
		'{1'b1, 1'b0, 3'h1, 1'b0, 3'h7, 32'h7456_3012},
		'{1'b1, 1'b1, 3'h0, 1'b1, 3'h5, 32'h5476_1032},
		'{1'b1, 1'b1, 3'h0, 1'b0, 3'h3, 32'h3210_7654}};

	always #12.5 clk = ~clk;

	ddbp_core ddbp_core_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(link_clk), .cmd_pins(cmd_pins), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .write_byte_mask(write_byte_mask),
		.strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n), .bank_open(bank_open));
	ddbp_ctl_model ddbp_ctl_model_i (.link_clk(link_clk), .cmd_pins(cmd_pins), .dq_in(dq_in),
		.write_byte_mask(write_byte_mask), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
		.strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n), .bank_open(bank_open));

	task automatic stop_test;
		$display("TB: %0d mismatches in %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				r = prdata;
				e = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		num_errors++;
		stop_test();
	endtask

	task automatic chkreg(input logic [7:0] a, input logic [31:0] v, input logic e);
		apb(1'b0, a, 32'h0000_0000, rd, er);
		`CHK({er, rd}, {e, v})
	endtask

	task automatic lk(input int k);
		repeat (k) @(posedge link_clk);
		#130;
	endtask

	task automatic act(input logic [1:0] b);
		ddbp_ctl_model_i.issue(3'b011, b, 13'h0000);
	endtask

	function automatic logic [22:0] sa(input int k);
		return ddbp_ctl_model_i.smp[8'(ddbp_ctl_model_i.c0 + k)];
	endfunction

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK({prdata, pready, pslverr, dq_oe_n, strobe_oe_n, bank_open}, {32'h0, 8'h30})
		chkreg(ddbp_pkg::MODE_OFS, ddbp_pkg::MODE_RST, 1'b0);
		chkreg(ddbp_pkg::EXT_OFS, ddbp_pkg::EXT_RST, 1'b0);
		chkreg(8'h0c, 32'h0000_0000, 1'b1);
		apb(1'b1, ddbp_pkg::STAT_OFS, 32'hffff_ffff, rd, er);
		chkreg(ddbp_pkg::STAT_OFS, 32'h0000_0000, 1'b0);
		apb(1'b1, ddbp_pkg::MODE_OFS, 32'h0000_043d, rd, er);
		chkreg(ddbp_pkg::MODE_OFS, 32'h0000_043a, 1'b0);
		for (int b = 0; b < 4; b++)
			act(2'(b));
		lk(2);
		`CHK(bank_open, 4'hf)
		for (int b = 0; b < 3; b++) begin
			ddbp_ctl_model_i.issue(3'b010, 2'(b), 13'h0000);
			lk(2);
			`CHK(bank_open, 4'hf << (b + 1))
		end
		ddbp_ctl_model_i.issue(3'b010, 2'h0, 13'h0400);
		lk(2);
		`CHK(bank_open, 4'h0)
		apb(1'b1, ddbp_pkg::MODE_OFS, 32'h0000_0433, rd, er);
		act(2'h1);
		for (int k = 0; k < 8; k++) begin
			w[k] = 16'h5a00 + 16'(k);
			m[k] = 2'h0;
			mem[k] = w[k];
		end
		ddbp_ctl_model_i.wr_burst(2'h1, 13'h0000, 2, 8, w, m);
		apb(1'b1, ddbp_pkg::MODE_OFS, 32'h0000_0432, rd, er);
		// Every mask combination once; masked bytes keep the fill pattern
		for (int k = 0; k < 4; k++) begin
			w[k] = 16'hc3f0 ^ 16'(k);
			m[k] = 2'(k);
			mem[k] = {m[k][1] ? mem[k][15:8] : w[k][15:8], m[k][0] ? mem[k][7:0] : w[k][7:0]};
		end
		ddbp_ctl_model_i.wr_burst(2'h1, 13'h0400, 2, 4, w, m);
		`CHK(sa(12) & 23'h02_0000, 23'h02_0000)
		`CHK(sa(14) & 23'h02_0000, 23'h00_0000)
		foreach (rows[i]) begin
			apb(1'b1, ddbp_pkg::EXT_OFS, 32'(rows[i].al) << 3, rd, er);
			apb(1'b1, ddbp_pkg::MODE_OFS, {28'h000_0043, rows[i].ilv, 3'h2 + 3'(rows[i].bl8)}, rd, er);
			act(2'h1);
			ddbp_ctl_model_i.rd_burst(2'h1, {2'h0, rows[i].close, 7'h00, rows[i].st}, i == 0);
			rl = 3 + int'(rows[i].al);
			n = rows[i].bl8 ? 8 : 4;
			ac = int'(rows[i].al) + n / 2;
			`CHK(sa(2 * rl - 4) & 23'h20_0000, 23'h20_0000)
			`CHK(sa(2 * rl - 2) & 23'h30_0000, 23'h00_0000)
			for (int b = 0; b < n; b++) begin
				`CHK(sa(2 * rl + b) & 23'h71_ffff, {3'(b % 2 == 0), 4'h0, mem[rows[i].ord[28 - 4 * b +: 3]]})
			end
			`CHK(sa(2 * ac - 2) & 23'h02_0000, 23'h02_0000)
			`CHK(sa(2 * ac) & 23'h02_0000, rows[i].close ? 23'h0 : 23'h02_0000)
		end
		// Length-eight read cut by a read two clocks on; strobe runs unbroken
		ddbp_ctl_model_i.issue(3'b101, 2'h1, 13'h0000);
		n = int'(ddbp_ctl_model_i.c0);
		ddbp_ctl_model_i.issue(3'b101, 2'h1, 13'h0004);
		ddbp_ctl_model_i.c0 = 8'(n);
		lk(12);
		for (int b = 0; b < 12; b++) begin
			ac = (b < 4) ? b : ((b - 4) ^ 4);
			`CHK(sa(6 + b) & 23'h70_ffff, {3'(b % 2 == 0), 4'h0, mem[ac]})
		end
		`CHK(sa(18) & 23'h60_0000, 23'h60_0000)
		stop_test();
	end
endmodule // ddr2_burst_precharge_logic_tb_top
